// ---- verilog/owh_host.sv ----
// Host controller driving the converter's serial port, with an APB register slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - voltage channel needs its setup gain updated
// - voltage gain via calibration or 0x55567C
// - current inputs keep input buffers off
// - voltage inputs enable input buffers
// - differential pairs only 0/1,2/3,4/5,6/7
// - single-ended inputs pair with common return
// - open wire needs config bits 12,13,6
// - open wire uses two equal channels
// - single-ended pairs 15/0,1/2 ... 13/14
// - differential pairs 1/2,5/6,9/10,13/14
// - flag open wire above code threshold
// - open wire writes 0x0040,0x3800,0x1300
// - each access starts with 8-bit command
// - 64 clocks with data high resets device
module owh_host
  import owh_pkg::*;
(
  input  wire logic        clk,      // 10 MHz system clock
  input  wire logic        rstn,     // Asynchronous reset, active low
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output owh_spi_t         spi_out,  // Serial clock, select, data to device
  input  wire logic        spi_miso  // Data from device
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0]  cmd_addr_reg;   // Target device register
  logic [1:0]  cmd_len_reg;    // Data bytes minus one
  logic [31:0] wdata_reg;      // Data to send
  logic [31:0] rdata_reg;      // Data received
  logic        done_reg;       // Sticky transfer complete
  logic        ow_flag_reg;    // Sticky open wire flag
  logic        ow_diff_reg;    // Differential pairing selected
  logic        ow_uni_reg;     // Unipolar coding selected
  logic [3:0]  ow_pair_reg;    // Pair index
  logic [23:0] ow_first_reg;   // First result of the pair
  logic [23:0] ow_absd_reg;    // Last difference seen
  logic        ow_half_reg;    // Waiting for second result
  logic        ow_run_reg;     // Read results for open wire check
  owh_state_t  state_reg;      // Serial engine state
  logic        rd_reg;         // Current transfer is a read
  logic [5:0]  bit_cnt_reg;    // Bits left in phase
  logic [3:0]  div_reg;        // Serial clock divider
  logic        tick;           // One-cycle half-period enable
  logic [31:0] shift_reg;      // Outgoing bits
  logic        start;          // Software launches a transfer
  logic        dev_reset;      // Software launches a device reset
  logic        busy;

  assign busy = (state_reg != ST_IDLE);
  assign tick = (div_reg == SCLK_HALF - 4'h1);

  // ----------------------------------------------------------------
  // APB slave: always ready in the access cycle
  // ----------------------------------------------------------------
  logic wr_en;
  assign wr_en     = psel && penable && pwrite;
  assign start     = wr_en && (paddr == A_CTRL) && pwdata[0] && !busy;
  assign dev_reset = wr_en && (paddr == A_CTRL) && pwdata[2] && !busy;

  // Ready and error answer in the access cycle itself
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        // Unmapped addresses read zero and flag an error
        if (paddr == A_CTRL) begin
          prdata <= {28'h0000000, ow_run_reg, 3'h0};
        end else if (paddr == A_CMD) begin
          prdata <= {22'h000000, cmd_len_reg, 2'h0, cmd_addr_reg};
        end else if (paddr == A_WDATA) begin
          prdata <= wdata_reg;
        end else if (paddr == A_RDATA) begin
          prdata <= rdata_reg;
        end else if (paddr == A_STATUS) begin
          prdata <= {29'h00000000, ow_flag_reg, done_reg, busy};
        end else if (paddr == A_OWCFG) begin
          prdata <= {24'h000000, ow_pair_reg, 2'h0, ow_uni_reg, ow_diff_reg};
        end else if (paddr == A_OWDIFF) begin
          prdata <= {8'h00, ow_absd_reg};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Configuration registers written by software
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_addr_reg <= 6'h00;
      cmd_len_reg  <= 2'h0;
      wdata_reg    <= 32'h00000000;
      ow_diff_reg  <= 1'b0;
      ow_uni_reg   <= 1'b0;
      ow_pair_reg  <= 4'h0;
      ow_run_reg   <= 1'b0;
    end else if (wr_en) begin
      if (paddr == A_CMD) begin
        cmd_addr_reg <= pwdata[5:0];
        cmd_len_reg  <= pwdata[9:8];
      end else if (paddr == A_WDATA) begin
        wdata_reg <= pwdata;
      end else if (paddr == A_OWCFG) begin
        ow_diff_reg <= pwdata[0];
        ow_uni_reg  <= pwdata[1];
        ow_pair_reg <= pwdata[7:4];
      end else if (paddr == A_CTRL) begin
        ow_run_reg <= pwdata[3];
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial clock divider: half-period enable, counting only while busy, held at zero when idle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 4'h0;
    end else if (tick || !busy) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Serial engine: mode 3, data changes on falling, sampled on rising
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_IDLE;
      spi_out     <= '{sclk: 1'b1, cs_n: 1'b1, mosi: 1'b1};
      bit_cnt_reg <= 6'h00;
      shift_reg   <= 32'h00000000;
      rd_reg      <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (dev_reset) begin
            // Data held high for the full reset length
            spi_out.cs_n <= 1'b0;
            spi_out.mosi <= 1'b1;
            bit_cnt_reg  <= 6'(RESET_SCLKS - 1);
            state_reg    <= ST_RESET;
          end else if (start) begin
            // Command byte precedes the data
            spi_out.cs_n <= 1'b0;
            rd_reg       <= pwdata[1];
            shift_reg    <= {owh_cmd(pwdata[1], cmd_addr_reg), 24'h000000};
            bit_cnt_reg  <= 6'd7;
            state_reg    <= ST_CMD;
          end
        end
        ST_RESET: begin
          if (tick) begin
            spi_out.sclk <= !spi_out.sclk;
            if (spi_out.sclk == 1'b0) begin
              if (bit_cnt_reg == 6'h00) begin
                state_reg <= ST_GAP;
              end else begin
                bit_cnt_reg <= bit_cnt_reg - 6'h01;
              end
            end
          end
        end
        ST_CMD, ST_DATA: begin
          if (tick) begin
            spi_out.sclk <= !spi_out.sclk;
            if (spi_out.sclk) begin
              // Falling edge: present next bit
              spi_out.mosi <= shift_reg[31];
              shift_reg    <= {shift_reg[30:0], 1'b0};
            end else if (bit_cnt_reg != 6'h00) begin
              bit_cnt_reg <= bit_cnt_reg - 6'h01;
            end else if (state_reg == ST_CMD) begin
              // Data length follows the command; send high bytes first
              state_reg   <= ST_DATA;
              bit_cnt_reg <= {cmd_len_reg, 3'h7};
              shift_reg   <= wdata_reg << (6'd8 * (6'd3 - {4'h0, cmd_len_reg}));
            end else begin
              state_reg <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // Release select and idle data high
          spi_out.cs_n <= 1'b1;
          spi_out.mosi <= 1'b1;
          spi_out.sclk <= 1'b1;
          state_reg    <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Read data capture on rising serial edges in the data phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h00000000;
    end else if (start) begin
      rdata_reg <= 32'h00000000;
    end else if (state_reg == ST_DATA && tick && !spi_out.sclk && rd_reg) begin
      rdata_reg <= {rdata_reg[30:0], spi_miso};
    end
  end

  // ----------------------------------------------------------------
  // Done flag: set wins over clear by software write of status bit 1
  // ----------------------------------------------------------------
  logic xfer_end;
  assign xfer_end = (state_reg == ST_GAP);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else if (xfer_end) begin
      done_reg <= 1'b1;
    end else if (wr_en && paddr == A_STATUS && pwdata[1]) begin
      done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Open wire check on data-plus-status reads of the result register
  // ----------------------------------------------------------------
  logic        ow_read;
  logic [3:0]  res_chan;
  logic [23:0] ow_thr;
  logic [3:0]  pair_lo;
  logic [3:0]  pair_hi;
  logic        ow_hit;   // Result belongs to the selected pair
  assign ow_read  = xfer_end && rd_reg && ow_run_reg && cmd_addr_reg == DEV_DATA;
  assign res_chan = rdata_reg[3:0];  // Appended status names the channel
  assign ow_thr   = ow_uni_reg ? OW_THR_UNI : OW_THR_BI;
  // Single-ended pair k is (2k-1, 2k); differential pair k is (4k+1, 4k+2)
  assign pair_lo  = ow_diff_reg ? {ow_pair_reg[1:0], 2'b01} : 4'(ow_pair_reg * 4'h2 - 4'h1);
  assign pair_hi  = ow_diff_reg ? {ow_pair_reg[1:0], 2'b10} : 4'(ow_pair_reg * 4'h2);
  // Pair members alternate in the sequence, so either may arrive first
  assign ow_hit   = ow_read && (res_chan == pair_lo || res_chan == pair_hi);

  // Two results per pair, then compare difference with threshold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ow_first_reg <= 24'h000000;
      ow_half_reg  <= 1'b0;
      ow_absd_reg  <= 24'h000000;
      ow_flag_reg  <= 1'b0;
    end else begin
      if (ow_hit && !ow_half_reg) begin
        // First of the two results is held until its partner arrives
        ow_first_reg <= rdata_reg[31:8];
        ow_half_reg  <= 1'b1;
      end else if (ow_hit) begin
        ow_half_reg <= 1'b0;
        ow_absd_reg <= owh_absdiff(ow_first_reg, rdata_reg[31:8]);
      end
      if (ow_hit && ow_half_reg && owh_absdiff(ow_first_reg, rdata_reg[31:8]) > ow_thr) begin
        ow_flag_reg <= 1'b1;
      end else if (wr_en && paddr == A_STATUS && pwdata[2]) begin
        ow_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_reset_high;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_RESET) |-> spi_out.mosi && !spi_out.cs_n;
  endproperty
  a_reset_high: assert property (p_reset_high) else $error("data low during reset");
  property p_cmd_len;
    @(posedge clk) disable iff (!rstn)
      $rose(state_reg == ST_CMD) |-> bit_cnt_reg == 6'd7;
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("command not eight bits");
  property p_cmd_first;
    @(posedge clk) disable iff (!rstn)
      $rose(state_reg == ST_DATA) |-> $past(state_reg) == ST_CMD;
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("data without command");
  property p_flag_thr;
    @(posedge clk) disable iff (!rstn)
      $rose(ow_flag_reg) |-> ow_absd_reg > ow_thr;
  endproperty
  a_flag_thr: assert property (p_flag_thr) else $error("flag below threshold");
  property p_pair_order;
    @(posedge clk) disable iff (!rstn)
      $rose(ow_flag_reg) |-> $past(ow_half_reg);
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("flag without pair");
  property p_cs_idle;
    @(posedge clk) disable iff (!rstn)
      (state_reg == ST_IDLE) && $past(state_reg == ST_GAP) |-> spi_out.cs_n;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("select held after transfer");
  property p_chan_pair;
    @(posedge clk) disable iff (!rstn)
      ow_read && ow_diff_reg |-> pair_hi == pair_lo + 4'h1;
  endproperty
  a_chan_pair: assert property (p_chan_pair) else $error("bad diff pair");
  property p_apb_ready;
    @(posedge clk) disable iff (!rstn)
      psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb not ready");

  c_reset: cover property (@(posedge clk) disable iff (!rstn) state_reg == ST_RESET);
  c_read:  cover property (@(posedge clk) disable iff (!rstn) xfer_end && rd_reg);
  c_flag:  cover property (@(posedge clk) disable iff (!rstn) $rose(ow_flag_reg));

endmodule

// ---- pkg/owh_pkg.sv ----
// Package for the host-side converter controller: register map, fields, constants, carriers
package owh_pkg;

  // ----------------------------------------------------------------
  // Device register map (6-bit register addresses within the 8-bit command)
  // ----------------------------------------------------------------
  localparam logic [5:0]  DEV_CONV_MODE   = 6'h01; // conversion_mode_control
  localparam logic [5:0]  DEV_IF_MODE     = 6'h02; // serial_interface_mode
  localparam logic [5:0]  DEV_GP_CFG      = 6'h06; // general_purpose_configuration
  localparam logic [5:0]  DEV_CHAN_BASE   = 6'h10; // channel register 0
  localparam logic [5:0]  DEV_SETUP_BASE  = 6'h20; // setup_zero_configuration
  localparam logic [5:0]  DEV_FILT_BASE   = 6'h28; // filter_config_setup_zero
  localparam logic [5:0]  DEV_OFFS_BASE   = 6'h30; // offset_coeff_setup_zero
  localparam logic [5:0]  DEV_GAIN_BASE   = 6'h38; // gain_coeff_setup_zero
  localparam logic [5:0]  DEV_DATA        = 6'h04; // conversion result register
  localparam logic [15:0] CONV_MODE_RST   = 16'h2000;
  localparam logic [15:0] IF_MODE_RST     = 16'h0000;
  localparam logic [15:0] FILT_RST        = 16'h0500;
  localparam logic [23:0] OFFS_RST        = 24'h800000;

  // ----------------------------------------------------------------
  // Open wire setup values and thresholds
  // ----------------------------------------------------------------
  localparam logic [15:0] OW_IF_MODE      = 16'h0040; // status appended to data
  localparam logic [15:0] OW_GP_CFG       = 16'h3800; // open wire bits 12 and 13
  localparam logic [15:0] OW_SETUP_BI     = 16'h1300; // buffers on, bipolar
  localparam logic [15:0] OW_SETUP_UNI    = 16'h0300; // buffers on, unipolar
  localparam logic [15:0] SETUP_CURRENT   = 16'h1000; // buffers off for current inputs
  localparam logic [23:0] GAIN_NOMINAL    = 24'h55567C; // voltage-input gain
  localparam logic [23:0] OW_THR_BI       = 24'h0186A0;
  localparam logic [23:0] OW_THR_UNI      = 24'h030D40;
  localparam logic [15:0] CH_SE_ZERO      = 16'h8010; // enable, input zero vs common
  localparam logic [15:0] CH_DIFF_ZERO_ONE = 16'h8001; // enable, input pair zero/one
  localparam int          RESET_SCLKS     = 64;

  // ----------------------------------------------------------------
  // Serial clock: 10 MHz system clock divided down
  // ----------------------------------------------------------------
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          SCLK_HZ         = 1_000_000;
  localparam logic [3:0]  SCLK_HALF       = 4'(CLK_HZ / SCLK_HZ / 2);

  // ----------------------------------------------------------------
  // APB register offsets of the controller
  // ----------------------------------------------------------------
  localparam logic [7:0]  A_CTRL          = 8'h00; // [0] go,[1] rd,[2] dev reset,[3] ow run
  localparam logic [7:0]  A_CMD           = 8'h04; // [5:0] addr, [9:8] byte count-1
  localparam logic [7:0]  A_WDATA         = 8'h08;
  localparam logic [7:0]  A_RDATA         = 8'h0C;
  localparam logic [7:0]  A_STATUS        = 8'h10; // [0] busy,[1] done,[2] ow flag
  localparam logic [7:0]  A_OWCFG         = 8'h14; // [0] diff,[1] unipolar,[3:0]@4 pair
  localparam logic [7:0]  A_OWDIFF        = 8'h18;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } owh_spi_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RESET, ST_CMD, ST_DATA, ST_GAP
  } owh_state_t;

  // Command byte: write-enable low, read flag, register address
  function automatic logic [7:0] owh_cmd(input logic rd, input logic [5:0] a);
    return {1'b0, rd, a};
  endfunction

  // Absolute difference of two results
  function automatic logic [23:0] owh_absdiff(input logic [23:0] a, input logic [23:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

endpackage

// ---- verification/owh_dev_model.sv ----
// Behavioural converter model: serial port, register file, channel sequencer
`timescale 1ns/1ps
module owh_dev_model
  import owh_pkg::*;
#(
  parameter logic [23:0] FACT_GAIN = 24'h5A5A50 // Arbitrary per-part gain
)(
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic [23:0] res [16], // Result per channel
  output logic             miso
);
  // ----------------------------------------------------------------
  // Register file and frame state
  // ----------------------------------------------------------------
  logic [15:0] conv_reg, ifm_reg, filt_reg, en_reg, setup_reg; // Modes, setup, enables
  logic [23:0] offs_reg, gain_reg;                   // Setup zero coefficients
  logic [31:0] sh_reg, out_reg;                      // Shift in and out
  logic [7:0]  cmd_reg;                              // Command byte
  logic [3:0]  cur_reg = 4'hF;                       // Last channel converted
  logic        last_reg = 1'b1;                      // Last bit driven
  int          cnt = 0, ones = 0;                    // Frame bits, run of ones

  // Released line shows the inverse of the last bit, never a stale copy
  assign miso = cs_n ? ~last_reg : last_reg;

  // Default state after power-on or serial reset
  task automatic dflt();
    conv_reg = CONV_MODE_RST;
    ifm_reg  = IF_MODE_RST;
    filt_reg = FILT_RST;
    offs_reg = OFFS_RST;
    gain_reg = FACT_GAIN;
    en_reg   = 16'h0001;
    setup_reg = SETUP_CURRENT; // input buffers bypassed
  endtask
  initial dflt();

  // Data bits that follow the command byte
  function automatic int width(input logic [5:0] a);
    if (a == DEV_OFFS_BASE || a == DEV_GAIN_BASE) return 24;
    if (a == DEV_DATA) return 32;
    return 16;
  endfunction

  // Read word, MSB first; result reads step upward through enabled channels
  task automatic load();
    case (cmd_reg[5:0])
      DEV_CONV_MODE: out_reg = {conv_reg, 16'h0};
      DEV_IF_MODE:   out_reg = {ifm_reg, 16'h0};
      DEV_FILT_BASE: out_reg = {filt_reg, 16'h0};
      DEV_SETUP_BASE: out_reg = {setup_reg, 16'h0};
      DEV_OFFS_BASE: out_reg = {offs_reg, 8'h0};
      DEV_GAIN_BASE: out_reg = {gain_reg, 8'h0};
      DEV_DATA: begin
        do cur_reg++; while (!en_reg[cur_reg] && en_reg != 16'h0);
        out_reg = {res[cur_reg], 4'h0, cur_reg};
      end
      default: out_reg = 32'h0;
    endcase
  endtask

  // Write lands only once the whole word has arrived
  task automatic store();
    case (cmd_reg[5:0])
      DEV_CONV_MODE: conv_reg = sh_reg[15:0];
      DEV_IF_MODE:   ifm_reg = sh_reg[15:0];
      DEV_FILT_BASE: filt_reg = sh_reg[15:0];
      DEV_SETUP_BASE: setup_reg = sh_reg[15:0];
      DEV_OFFS_BASE: offs_reg = sh_reg[23:0];
      DEV_GAIN_BASE: gain_reg = sh_reg[23:0];
      default: if (cmd_reg[5:4] == 2'b01) en_reg[cmd_reg[3:0]] = sh_reg[15];
    endcase
  endtask

  // Sample on rising serial clock: reset run, command byte, then data
  always @(posedge sclk) begin
    if (!cs_n) begin
      ones = mosi ? ones + 1 : 0;
      if (ones == RESET_SCLKS) begin
        dflt();
        cnt = 0;
      end else begin
        if (cnt < 8) cmd_reg = {cmd_reg[6:0], mosi};
        else sh_reg = {sh_reg[30:0], mosi};
        cnt++;
        if (cnt == 8 && cmd_reg[7:6] == 2'b01) load();
        if (cnt == 8 + width(cmd_reg[5:0]) && cmd_reg[7:6] == 2'b00) store();
      end
    end
  end

  // Select rising ends the frame
  always @(posedge cs_n) begin
    cnt = 0;
    ones = 0;
  end

  // Drive on the falling edge so the host samples a settled bit
  always @(negedge sclk) begin
    if (!cs_n && cnt >= 8 && cmd_reg[7:6] == 2'b01) begin
      last_reg = out_reg[31];
      out_reg = out_reg << 1;
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the host converter controller
`timescale 1ns/1ps
module tb_top;
  import owh_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [23:0] FACT_GAIN = 24'h5A5A50; // Arbitrary per-part gain
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, miso;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] res [16];      // Results the model hands out
  logic        ow_run;        // Open wire run bit for frames
  owh_spi_t    spi;           // Serial lines from the host
  int          err_total, checks_done;
  logic [5:0]  reg_a [6] = '{DEV_CONV_MODE, DEV_IF_MODE, DEV_FILT_BASE, DEV_SETUP_BASE,
                             DEV_OFFS_BASE, DEV_GAIN_BASE};
  logic [31:0] reg_d [6] = '{32'(CONV_MODE_RST), 32'(IF_MODE_RST), 32'(FILT_RST),
                             32'(SETUP_CURRENT), 32'(OFFS_RST), 32'(FACT_GAIN)};

  owh_host dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_out(spi), .spi_miso(miso));
  owh_dev_model #(.FACT_GAIN(FACT_GAIN)) u_dev (.sclk(spi.sclk), .cs_n(spi.cs_n),
    .mosi(spi.mosi), .res(res), .miso(miso));

  always #50 clk = ~clk; // 10 MHz

  task automatic chk(input string s, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", s, exp, got);
    end
  endtask

  // One APB transfer: setup, then access held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk("pready", 1, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // One device register access through the controller, waits for done
  task automatic xfer(input logic r, input logic [5:0] a, input logic [1:0] nb1,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    wr(A_WDATA, d);
    wr(A_CMD, {22'h0, nb1, 2'h0, a});
    wr(A_CTRL, {28'h0, ow_run, 1'b0, r, 1'b1});
    n = 0;
    do begin
      rdr(A_STATUS, q);
      n++;
    end while (q[1] !== 1'b1 && n < 400);
    chk("frame done", 1, q[1]);
    rdr(A_RDATA, q);
    wr(A_STATUS, 32'h2);
  endtask

  // Serial reset of the device; waits until the controller is idle
  task automatic devrst();
    logic [31:0] q;
    int          n;
    wr(A_CTRL, 32'h4);
    n = 0;
    do begin
      rdr(A_STATUS, q);
      n++;
    end while (q[0] !== 1'b0 && n < 800);
    chk("reset idle", 0, q[0]);
    wr(A_STATUS, 32'h2);
  endtask

  task automatic t_apb();
    logic [31:0] q;
    logic        e;
    apb(1'b0, A_STATUS, 32'h0, q, e);
    chk("status at reset", 0, q);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
    wr(A_OWCFG, 32'h73);
    rdr(A_OWCFG, q);
    chk("pair config", 32'h73, q);
    $display("test register bus done");
  endtask

  // Power-on values, read-write access, then serial reset restores defaults
  task automatic t_regs();
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, reg_a[i], i < 4 ? 2'd1 : 2'd2, 32'h0, q);
      chk("power-on value", reg_d[i], q);
      xfer(1'b0, reg_a[i], i < 4 ? 2'd1 : 2'd2, reg_d[i] ^ 32'h5A5A, q);
      xfer(1'b1, reg_a[i], i < 4 ? 2'd1 : 2'd2, 32'h0, q);
      chk("read back", reg_d[i] ^ 32'h5A5A, q);
    end
    devrst();
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, reg_a[i], i < 4 ? 2'd1 : 2'd2, 32'h0, q);
      chk("value after reset", reg_d[i], q);
    end
    $display("test device registers done");
  endtask

  // Open wire run on one channel pair; flag judged from the threshold
  task automatic t_ow(input logic df, input logic un, input logic [3:0] k,
                      input logic [3:0] ca, input logic [3:0] cb,
                      input logic [23:0] va, input logic [23:0] vb);
    logic [31:0] q;
    logic [23:0] dv;
    logic        lo;
    logic [31:0] cw;   // Channel word used by both members of the pair
    dv = (va > vb) ? va - vb : vb - va;
    lo = ca < cb;
    res[ca] = va;
    res[cb] = vb;
    ow_run = 1'b0;
    devrst();
    xfer(1'b0, DEV_IF_MODE, 2'd1, 32'(OW_IF_MODE), q);
    xfer(1'b0, DEV_GP_CFG, 2'd1, 32'(OW_GP_CFG), q);
    xfer(1'b0, DEV_SETUP_BASE, 2'd1, un ? 32'(OW_SETUP_UNI) : 32'(OW_SETUP_BI), q);
    xfer(1'b0, DEV_GAIN_BASE, 2'd2, 32'(GAIN_NOMINAL), q);
    xfer(1'b0, DEV_CHAN_BASE, 2'd1, 32'h0, q);
    cw = df ? 32'(CH_DIFF_ZERO_ONE) : 32'(CH_SE_ZERO);
    xfer(1'b0, DEV_CHAN_BASE + 6'(ca), 2'd1, cw, q);
    xfer(1'b0, DEV_CHAN_BASE + 6'(cb), 2'd1, cw, q);
    wr(A_OWCFG, {24'h0, k, 2'b00, un, df});
    wr(A_STATUS, 32'h4);
    ow_run = 1'b1;
    xfer(1'b1, DEV_DATA, 2'd3, 32'h0, q);
    chk("first result", {lo ? va : vb, lo ? ca : cb}, {q[31:8], q[3:0]});
    xfer(1'b1, DEV_DATA, 2'd3, 32'h0, q);
    chk("second result", {lo ? vb : va, lo ? cb : ca}, {q[31:8], q[3:0]});
    ow_run = 1'b0;
    rdr(A_OWDIFF, q);
    chk("pair difference", 32'(dv), q);
    rdr(A_STATUS, q);
    chk("open wire flag", 32'(dv > (un ? OW_THR_UNI : OW_THR_BI)), q[2]);
    $display("test open wire pair %0d done", k);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under this span
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ow_run = 1'b0;
    foreach (res[i]) res[i] = 24'h800000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_apb();
    t_regs();
    t_ow(1'b0, 1'b0, 4'd0, 4'd15, 4'd0, 24'h8B4D6F, 24'h8ED5D8);
    t_ow(1'b1, 1'b1, 4'd0, 4'd1, 4'd2, 24'h850000, 24'h82B610);
    t_ow(1'b0, 1'b0, 4'd7, 4'd13, 4'd14, 24'h800000, 24'h8186A0);
    t_ow(1'b1, 1'b0, 4'd1, 4'd5, 4'd6, 24'h8186A1, 24'h800000);
    give_verdict();
  end
endmodule
